// File: shared/seclock_pkg.sv
// Constants and types shared by the write-once security lock
package seclock_pkg;

  // ************************************************************
  // Sizes and thresholds
  // ************************************************************
  localparam int KEY_W = 32;
  localparam int MATCH_MIN = 28;
  localparam int NUM_BLOCKS = 4;
  localparam int BLK_W = 2;
  localparam int PROT_W = 2;

  // Arbitrary reference pattern, not any real part's key
  localparam logic [KEY_W-1:0] KEY_DEFAULT = 32'h3c5a_a5c3;
  // Power-up contents of the cells, arbitrary
  localparam logic [KEY_W-1:0] CELLS_INIT = 32'h0000_0000;
  localparam logic [KEY_W-1:0] STAGE_RST = 32'h0000_0000;

  // ************************************************************
  // Protection levels
  // ************************************************************
  localparam logic [PROT_W-1:0] PROT_NONE = 2'h0;
  localparam logic [PROT_W-1:0] PROT_VERIFY_ONLY = 2'h1;

  // ************************************************************
  // Commands, flash requests, states
  // ************************************************************
  typedef enum logic [2:0] {
    OP_LOAD_KEY = 3'h0,
    OP_COMMIT = 3'h1,
    OP_READ_LATCH = 3'h2,
    OP_ERASE_ALL = 3'h3,
    OP_ERASE_BLK = 3'h4,
    OP_PROG_BLK = 3'h5,
    OP_VERIFY_BLK = 3'h6,
    OP_RAISE_PROT = 3'h7
  } op_t;

  typedef enum logic [1:0] {
    FL_ERASE_ALL = 2'h0,
    FL_ERASE = 2'h1,
    FL_PROG = 2'h2,
    FL_VERIFY = 2'h3
  } flash_kind_t;

  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_OPEN = 3'b010,
    ST_LOCKED = 3'b100
  } lock_state_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic [BLK_W-1:0] blk;
    logic [KEY_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic [KEY_W-1:0] data;
  } rsp_t;

  typedef struct packed {
    logic valid;
    flash_kind_t kind;
    logic all;
    logic [BLK_W-1:0] blk;
  } flash_op_t;

endpackage

// File: src/nonvolatile_latch_cells.sv
// Write-once latch cells with volatile stage and match wrapper
`timescale 1ns/1ps
module nonvolatile_latch_cells #(
  parameter int KEY_W = seclock_pkg::KEY_W,
  parameter int MATCH_MIN = seclock_pkg::MATCH_MIN,
  parameter logic [KEY_W-1:0] REF_KEY = seclock_pkg::KEY_DEFAULT
) (
  // Clock and resets
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic powerOnRst,
  // Stage and commit
  input wire logic loadEn,
  input wire logic [KEY_W-1:0] loadData,
  input wire logic commitEn,
  // Read side
  output logic [KEY_W-1:0] cellsOut,
  output logic matchOut
);
  import seclock_pkg::*;

  localparam int CNT_W = $clog2(KEY_W + 1);

  logic [KEY_W-1:0] stageReg, stageNext;
  logic [KEY_W-1:0] cellsReg, cellsNext;
  logic [KEY_W-1:0] eqBits;
  logic [CNT_W-1:0] matchCount;

  genvar gi;
  generate
    for (gi = 0; gi < KEY_W; gi++) begin : g_eq
      assign eqBits[gi] = (cellsReg[gi] == REF_KEY[gi]);
    end
  endgenerate

  always_comb begin
    matchCount = '0;
    for (int i = 0; i < KEY_W; i++) begin
      matchCount = matchCount + CNT_W'(eqBits[i]);
    end
    stageNext = loadEn ? loadData : stageReg;
    cellsNext = commitEn ? stageReg : cellsReg;
  end

  // Cells survive system reset; only power-up defines them
  always_ff @(posedge clock) begin
    if (powerOnRst) begin
      cellsReg <= CELLS_INIT;
    end else begin
      cellsReg <= cellsNext;
    end
    if (sys_rst) begin
      stageReg <= STAGE_RST;
    end else begin
      stageReg <= stageNext;
    end
    cellsOut <= cellsReg;
    matchOut <= (matchCount >= CNT_W'(MATCH_MIN));
  end

  AST_MATCH_THRESHOLD: assert property (
    @(posedge clock) disable iff (powerOnRst)
    1 |=> matchOut == ($countones(~($past(cellsReg) ^ REF_KEY)) >= MATCH_MIN))
    else $error("latch output disagrees with bit match count");

  AST_COMMIT_COPIES: assert property (
    @(posedge clock) disable iff (powerOnRst || sys_rst)
    commitEn |=> cellsReg == $past(stageReg))
    else $error("commit did not copy the volatile stage");

endmodule

// File: src/write_once_security_lock.sv
// Security lock: reset-time latch sampling, access gate, flash protection
`timescale 1ns/1ps
module write_once_security_lock #(
  parameter logic [seclock_pkg::KEY_W-1:0] REF_KEY = seclock_pkg::KEY_DEFAULT
) (
  // Clock and resets
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic powerOnRst,
  // Debug link pins
  input wire logic debugLinkClockPin,
  input wire logic linkDataIn,
  output logic linkDataOut,
  output logic linkDataOeN,
  // Internal debug core side
  output logic coreClk,
  output logic coreDataIn,
  input wire logic coreDataOut,
  input wire logic coreDataDrive,
  // Decoded debug commands
  input wire seclock_pkg::cmd_t cmd,
  output seclock_pkg::rsp_t rsp,
  // Flash controller requests
  output seclock_pkg::flash_op_t flashOp,
  // Status
  output logic accessOpen,
  output logic lockActive
);
  import seclock_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic clkSync1, clkSync2, dataSync1, dataSync2;

  always_ff @(posedge clock) begin
    clkSync1 <= debugLinkClockPin;
    clkSync2 <= clkSync1;
    dataSync1 <= linkDataIn;
    dataSync2 <= dataSync1;
  end

  // ************************************************************
  // Latch cells
  // ************************************************************
  logic loadEn, commitEn, matchOut;
  logic [KEY_W-1:0] cellsOut;

  nonvolatile_latch_cells #(
    .KEY_W(KEY_W),
    .MATCH_MIN(MATCH_MIN),
    .REF_KEY(REF_KEY)
  ) u_cells (
    .clock(clock),
    .sys_rst(sys_rst),
    .powerOnRst(powerOnRst),
    .loadEn(loadEn),
    .loadData(cmd.data),
    .commitEn(commitEn),
    .cellsOut(cellsOut),
    .matchOut(matchOut)
  );

  // ************************************************************
  // Lock state and protection
  // ************************************************************
  lock_state_t stateReg, stateNext;
  logic [PROT_W-1:0] protReg [NUM_BLOCKS];
  logic [PROT_W-1:0] protNext [NUM_BLOCKS];
  rsp_t rspNext;
  flash_op_t flashNext;
  logic anyProt, openNow, blkOk, verifyOk;
  logic [PROT_W-1:0] curProt;

  always_comb begin
    stateNext = stateReg;
    rspNext = '0;
    flashNext = '0;
    loadEn = 1'b0;
    commitEn = 1'b0;
    anyProt = 1'b0;
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      protNext[i] = protReg[i];
      anyProt = anyProt | (protReg[i] != PROT_NONE);
    end
    curProt = protReg[cmd.blk];
    openNow = (stateReg == ST_OPEN);
    // level zero allows all, one only verify
    blkOk = (curProt == PROT_NONE);
    verifyOk = blkOk || (curProt == PROT_VERIFY_ONLY);
    case (stateReg)
      // capture the latch output once, after release
      ST_SAMPLE: stateNext = matchOut ? ST_LOCKED : ST_OPEN;
      ST_OPEN: stateNext = ST_OPEN;
      ST_LOCKED: stateNext = ST_LOCKED;
      default: stateNext = ST_LOCKED;
    endcase
    if (cmd.valid) begin
      rspNext.done = 1'b1;
      case (cmd.op)
        OP_READ_LATCH: begin
          rspNext.ok = 1'b1;
          rspNext.data = cellsOut;
        end
        // key accepted only with no protection
        OP_LOAD_KEY: begin
          // a matching latch is never altered
          rspNext.ok = openNow && !anyProt && !matchOut;
          loadEn = rspNext.ok;
        end
        OP_COMMIT: begin
          rspNext.ok = openNow && !anyProt && !matchOut;
          commitEn = rspNext.ok;
        end
        OP_ERASE_ALL: begin
          rspNext.ok = openNow;
          flashNext.valid = openNow;
          flashNext.kind = FL_ERASE_ALL;
          flashNext.all = 1'b1;
          // the only command path back to unprotected
          if (openNow) begin
            for (int i = 0; i < NUM_BLOCKS; i++) begin
              protNext[i] = PROT_NONE;
            end
          end
        end
        OP_ERASE_BLK, OP_PROG_BLK: begin
          rspNext.ok = openNow && blkOk;
          flashNext.valid = rspNext.ok;
          flashNext.kind = (cmd.op == OP_PROG_BLK) ? FL_PROG : FL_ERASE;
          flashNext.blk = cmd.blk;
        end
        OP_VERIFY_BLK: begin
          rspNext.ok = openNow && verifyOk;
          flashNext.valid = rspNext.ok;
          flashNext.kind = FL_VERIFY;
          flashNext.blk = cmd.blk;
        end
        // raise only; a lower level is refused
        OP_RAISE_PROT: begin
          rspNext.ok = openNow && (cmd.data[PROT_W-1:0] >= curProt);
          if (rspNext.ok) begin
            protNext[cmd.blk] = cmd.data[PROT_W-1:0];
          end
        end
        default: rspNext.ok = 1'b0;
      endcase
    end
  end

  // a fresh key changes nothing until the next reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stateReg <= ST_SAMPLE;
      rsp <= '0;
      flashOp <= '0;
    end else begin
      stateReg <= stateNext;
      rsp <= rspNext;
      flashOp <= flashNext;
    end
  end

  // Protection lives in flash; of the resets, only power-up clears the copy here
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      if (powerOnRst) begin
        protReg[i] <= PROT_NONE;
      end else begin
        protReg[i] <= protNext[i];
      end
    end
  end

  // ************************************************************
  // Access gate on the debug link
  // ************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accessOpen <= 1'b0;
      lockActive <= 1'b0;
      coreClk <= 1'b0;
      coreDataIn <= 1'b0;
      linkDataOut <= 1'b0;
      linkDataOeN <= 1'b1;
    end else begin
      accessOpen <= (stateNext == ST_OPEN);
      lockActive <= (stateNext == ST_LOCKED);
      // locked part passes nothing either way
      // host clock in, data both ways
      coreClk <= clkSync2 && (stateReg == ST_OPEN);
      coreDataIn <= dataSync2 && (stateReg == ST_OPEN);
      linkDataOut <= coreDataOut && (stateReg == ST_OPEN);
      linkDataOeN <= !(coreDataDrive && (stateReg == ST_OPEN));
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_locked_quiet;
    !coreClk && !coreDataIn && linkDataOeN;
  endsequence

  AST_LOCK_BLOCKS_LINK: assert property (
    @(posedge clock) disable iff (sys_rst)
    stateReg == ST_LOCKED |=> s_locked_quiet)
    else $error("locked part still passes debug link traffic");

  AST_SAMPLE_ONCE: assert property (
    @(posedge clock) disable iff (sys_rst)
    stateReg == ST_SAMPLE |=> (stateReg == ST_LOCKED) == $past(matchOut))
    else $error("lock state does not follow latch output at release");

  AST_LOCK_HOLDS: assert property (
    @(posedge clock) disable iff (sys_rst)
    stateReg == ST_LOCKED |=> stateReg == ST_LOCKED)
    else $error("lock released without reset");

  AST_MATCH_REFUSES_KEY: assert property (
    @(posedge clock) disable iff (sys_rst)
    cmd.valid && cmd.op inside {OP_LOAD_KEY, OP_COMMIT} && matchOut |=> rsp.done && !rsp.ok)
    else $error("latch changed while its output is high");

  AST_PROT_REFUSES_KEY: assert property (
    @(posedge clock) disable iff (sys_rst)
    cmd.valid && cmd.op == OP_LOAD_KEY && anyProt |=> !rsp.ok ##0 !$past(loadEn))
    else $error("key accepted while flash protection set");

  sequence s_key_taken;
    cmd.valid && cmd.op == OP_LOAD_KEY && loadEn;
  endsequence

  AST_OPEN_AFTER_KEY: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_key_taken |=> accessOpen [*3])
    else $error("access closed after key write without reset");

  AST_READ_LATCH: assert property (
    @(posedge clock) disable iff (sys_rst)
    cmd.valid && cmd.op == OP_READ_LATCH |=> rsp.ok && rsp.data == $past(cellsOut))
    else $error("latch read returned wrong contents");

  AST_NO_LOWERING: assert property (
    @(posedge clock) disable iff (sys_rst)
    cmd.valid && cmd.op == OP_RAISE_PROT && cmd.data[PROT_W-1:0] < curProt
    |=> !rsp.ok && protReg[$past(cmd.blk)] == $past(curProt))
    else $error("protection lowered without full erase");

  AST_BLOCK_GUARD: assert property (
    @(posedge clock) disable iff (sys_rst)
    cmd.valid && cmd.op == OP_PROG_BLK && curProt != PROT_NONE |=> !flashOp.valid)
    else $error("program issued to a protected block");

  AST_ERASE_ALL: assert property (
    @(posedge clock) disable iff (sys_rst)
    cmd.valid && cmd.op == OP_ERASE_ALL && openNow
    |=> flashOp.valid && flashOp.all ##1 !anyProt)
    else $error("full erase not issued or protection kept");

endmodule

// File: verif/debug_host_model.sv
// Behavioural debug host driving the two-wire link pins
`timescale 1ns/1ps
module debug_host_model (
  // Clock
  input wire logic clock,
  // Device side of the link
  input wire logic linkDataOut,
  input wire logic linkDataOeN,
  output logic debugLinkClockPin,
  output logic linkDataIn
);
  logic hostData;
  logic hostDrive;

  assign linkDataIn = !linkDataOeN ? linkDataOut : (hostDrive ? hostData : ~hostData);

  initial begin
    debugLinkClockPin = 1'b0;
    hostData = 1'b0;
    hostDrive = 1'b0;
  end

  task automatic frame(input logic [7:0] bits);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      hostDrive <= 1'b1;
      hostData <= bits[i];
      repeat (4) @(posedge clock);
      debugLinkClockPin <= 1'b1;
      repeat (4) @(posedge clock);
      debugLinkClockPin <= 1'b0;
    end
    @(posedge clock);
    hostDrive <= 1'b0;
  endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the security lock
`timescale 1ns/1ps
module testbench;
  import seclock_pkg::*;
  typedef struct packed {
    logic ok;
    logic chk;
    logic [31:0] data;
    logic fv;
    flash_kind_t fk;
    logic [1:0] b;
  } exp_t;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic powerOnRst = 1'b1;
  logic coreDataOut = 1'b0;
  logic coreDataDrive = 1'b0;
  logic debugLinkClockPin, linkDataIn, linkDataOut, linkDataOeN, coreClk, coreDataIn;
  logic accessOpen, lockActive, coreClkQ;
  cmd_t cmd = '0;
  rsp_t rsp;
  flash_op_t flashOp;
  exp_t expq[$];
  exp_t ex;
  int num_errors = 0;
  int check_count = 0;
  int rxCount = 0;
  logic [7:0] rxByte;
  logic [31:0] rnd = 32'h0001_5995;
  logic [31:0] k4, k5;

  always #2.5 clock = ~clock;

  write_once_security_lock DUT (.clock(clock), .sys_rst(sys_rst), .powerOnRst(powerOnRst),
    .debugLinkClockPin(debugLinkClockPin), .linkDataIn(linkDataIn),
    .linkDataOut(linkDataOut), .linkDataOeN(linkDataOeN), .coreClk(coreClk),
    .coreDataIn(coreDataIn), .coreDataOut(coreDataOut), .coreDataDrive(coreDataDrive),
    .cmd(cmd), .rsp(rsp), .flashOp(flashOp), .accessOpen(accessOpen),
    .lockActive(lockActive));

  debug_host_model host (.clock(clock), .linkDataOut(linkDataOut),
    .linkDataOeN(linkDataOeN), .debugLinkClockPin(debugLinkClockPin),
    .linkDataIn(linkDataIn));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input op_t op, input logic [1:0] blk, input logic [31:0] d,
                      input logic ok, input logic fv = 1'b0,
                      input flash_kind_t fk = FL_ERASE_ALL);
    exp_t e;
    e = '{ok, op == OP_READ_LATCH, d, fv, fk, blk};
    @(posedge clock);
    cmd <= '{1'b1, op, blk, d};
    expq.push_back(e);
  endtask

  task automatic idle;
    @(posedge clock);
    cmd <= '0;
    repeat (3) @(posedge clock);
  endtask

  // Cells survive this reset unless por is set
  task automatic do_reset(input logic por);
    @(posedge clock);
    cmd <= '0;
    sys_rst <= 1'b1;
    powerOnRst <= por;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    powerOnRst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic status(input logic open);
    @(negedge clock);
    check(accessOpen, open);
    check(lockActive, !open);
  endtask

  task automatic link(input logic open);
    int c0;
    logic [7:0] b;
    rnd = step(rnd);
    b = rnd[7:0];
    c0 = rxCount;
    host.frame(b);
    repeat (4) @(posedge clock);
    check(rxCount - c0, open ? 8 : 0);
    if (open) check(rxByte, b);
    coreDataDrive <= 1'b1;
    coreDataOut <= b[0];
    @(posedge clock);
    @(negedge clock);
    check(linkDataOeN, !open);
    if (open) check(linkDataOut, b[0]);
    @(posedge clock);
    coreDataDrive <= 1'b0;
  endtask

  // ************************************************************
  // Observers
  // ************************************************************
  always @(posedge clock) begin
    coreClkQ <= coreClk;
    if (coreClk && !coreClkQ) begin
      rxCount <= rxCount + 1;
      rxByte <= {coreDataIn, rxByte[7:1]};
    end
  end

  // Oldest note is matched to each answer
  always @(negedge clock) begin
    if (rsp.done === 1'b1) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("wrong value at %0t: answer without request", $time);
      end else begin
        ex = expq.pop_front();
        check(rsp.ok, ex.ok);
        if (ex.chk) check(rsp.data, ex.data);
        check(flashOp.valid, ex.fv);
        if (ex.fv) check({flashOp.kind, flashOp.all}, {ex.fk, ex.fk == FL_ERASE_ALL});
        if (ex.fv && ex.fk != FL_ERASE_ALL) check(flashOp.blk, ex.b);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("wrong value at %0t: run hung", $time);
    wrap_up;
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    do_reset(1'b1);
    status(1'b1);
    send(OP_READ_LATCH, 2'h0, CELLS_INIT, 1'b1);
    idle;
    link(1'b1);
    rnd = step(rnd);
    send(OP_ERASE_BLK, 2'h0, rnd, 1'b1, 1'b1, FL_ERASE);
    send(OP_RAISE_PROT, 2'h0, 32'h1, 1'b1);
    send(OP_PROG_BLK, 2'h0, rnd, 1'b0);
    send(OP_VERIFY_BLK, 2'h0, rnd, 1'b1, 1'b1, FL_VERIFY);
    send(OP_RAISE_PROT, 2'h1, 32'h2, 1'b1);
    send(OP_VERIFY_BLK, 2'h1, rnd, 1'b0);
    send(OP_RAISE_PROT, 2'h1, 32'h1, 1'b0);
    send(OP_LOAD_KEY, 2'h0, KEY_DEFAULT, 1'b0);
    send(OP_COMMIT, 2'h0, rnd, 1'b0);
    send(OP_ERASE_ALL, 2'h0, rnd, 1'b1, 1'b1, FL_ERASE_ALL);
    send(OP_PROG_BLK, 2'h1, rnd, 1'b1, 1'b1, FL_PROG);
    idle;
    // Spread flips so 27 then 28 bits still match
    rnd = step(rnd);
    k4 = KEY_DEFAULT ^ (32'h0101_0101 << rnd[2:0]);
    k5 = k4 ^ (32'h0000_0010 << rnd[2:0]);
    send(OP_LOAD_KEY, 2'h0, k5, 1'b1);
    send(OP_COMMIT, 2'h0, rnd, 1'b1);
    // Read copy lags a commit by one cycle
    idle;
    send(OP_READ_LATCH, 2'h0, k5, 1'b1);
    idle;
    do_reset(1'b0);
    status(1'b1);
    send(OP_LOAD_KEY, 2'h0, k4, 1'b1);
    send(OP_COMMIT, 2'h0, rnd, 1'b1);
    idle;
    send(OP_READ_LATCH, 2'h0, k4, 1'b1);
    send(OP_LOAD_KEY, 2'h0, k5, 1'b0);
    send(OP_RAISE_PROT, 2'h2, 32'h1, 1'b1);
    send(OP_VERIFY_BLK, 2'h2, rnd, 1'b1, 1'b1, FL_VERIFY);
    idle;
    status(1'b1);
    do_reset(1'b0);
    status(1'b0);
    send(OP_LOAD_KEY, 2'h0, k5, 1'b0);
    send(OP_ERASE_ALL, 2'h0, rnd, 1'b0);
    send(OP_READ_LATCH, 2'h0, k4, 1'b1);
    idle;
    link(1'b0);
    check(expq.size(), 0);
    wrap_up;
  end
endmodule
